// >>> hdl/tmc_pkg.sv
// Purpose: Shared constants and field layouts for the gated 16-bit timer/counter
// Assumes: APB word registers; register index times four gives the byte address
// Notes: Field structs follow the bit order of each register, bit 7 first
package tmc_pkg;
    // Register indices, byte address is index * 4
    localparam logic [13:0] IDX_GATE_CONTROL = 14'h0f9a;
    localparam logic [13:0] IDX_TIMER_CONTROL = 14'h0fcd;
    localparam logic [13:0] IDX_COUNT_LOW = 14'h0fce;
    localparam logic [13:0] IDX_COUNT_HIGH = 14'h0fcf;
    localparam logic [13:0] IDX_CLOCK_STATUS = 14'h0fd0;
    // Values after reset
    localparam logic [7:0] TIMER_CONTROL_RST = 8'h00;
    localparam logic [7:0] GATE_CONTROL_RST = 8'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    // Clock status register bit positions
    localparam int STAT_SEC_RUNNING = 0;
    localparam int STAT_OVERFLOW = 1;
    localparam int STAT_SYS_SEL_LO = 2;
    localparam int STAT_IDLE_ON_SLEEP = 4;
    // Last phase of the instruction clock, which is system clock over four
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
    // Clock source encodings
    localparam logic [1:0] CS_INSTR = 2'h0;
    localparam logic [1:0] CS_SYSTEM = 2'h1;
    localparam logic [1:0] CS_EXTERNAL = 2'h2;
    // Gate source encodings
    localparam logic [1:0] GS_PIN = 2'h0;
    localparam logic [1:0] GS_TIMER2 = 2'h1;
    localparam logic [1:0] GS_CMP1 = 2'h2;
    localparam logic [1:0] GS_CMP2 = 2'h3;
    // System clock select value that picks the crystal
    localparam logic [1:0] SYS_SEL_CRYSTAL = 2'h1;

    // Timer control fields, bit 7 down to bit 0
    typedef struct packed {
        logic [1:0] clock_source_select;
        logic [1:0] prescale_select;
        logic crystal_osc_enable;
        logic ext_sync_bypass;
        logic wide_access_enable;
        logic timer_on;
    } tmc_ctrl_s;

    // Gate control fields, bit 7 down to bit 0
    typedef struct packed {
        logic gate_count_enable;
        logic gate_polarity;
        logic gate_toggle_mode;
        logic gate_single_pulse_mode;
        logic pulse_arm_done;
        logic gate_level_status;
        logic [1:0] gate_source_select;
    } tmc_gate_s;

    // Power states, one-hot
    typedef enum logic [2:0] {
        PWR_PRIMARY = 3'h1,
        PWR_SECONDARY_RUN_STATE = 3'h2,
        PWR_SECONDARY_IDLE_STATE = 3'h4
    } tmc_pwr_e;
endpackage

// >>> hdl/tmc_timer.sv
// Purpose: Gated 16-bit timer/counter with APB registers and clock status
// Assumes: pclk is the system clock; all pins are asynchronous to it
// Notes: Pins pass two flops; bus answers with zero wait states
// Functional notes
// - Gate enable ignored when timer is off
// - Polarity bit picks active gate level
// - Toggle flip-flop held clear when mode off
// - Single pulse mode controls the gate
// - Arm bit high while waiting for pulse
// - Clearing pulse mode clears arm bit
// - Gate status shows current gate level
// - Gate source mux: pin, timer2, comparators
// - Internal clock increments per instruction cycle
// - External rising edges counted, sync optional
// - Timer on forces pins input, read zero
// - Clock source and oscillator select
// - Counter mode needs falling edge first
// - Low read copies high byte to buffer
// - Low write moves buffer into high byte
// - Only low write clears prescaler
// - Crystal oscillator stays powered in all modes
// - Crystal select enters secondary run, sleep idles when idle-on-sleep bit clear
// - Secondary running flag follows crystal clocking
// - Prescaler divides by 1, 2, 4, 8
// - Sync bypass only matters for external source
// - Rollover from ffff latches overflow flag
`timescale 1ns/1ns
module tmc_timer
    import tmc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_count_input,
    input wire logic crystal_in_pin,
    input wire logic crystal_osc_clk,
    input wire logic gate_pin,
    input wire logic comparator1_out,
    input wire logic comparator2_out,
    input wire logic timer2_match_pulse,
    input wire logic [1:0] port_direction,
    input wire logic sleep_request,
    input wire logic wake_request,
    output logic [1:0] crystal_pin_oe,
    output logic [1:0] crystal_pin_read,
    output logic crystal_osc_power,
    output logic secondary_clock_running,
    output logic [2:0] power_state
);
    localparam int NSYNC = 6;

    // Register state
    tmc_ctrl_s ctrl_q; // Timer control
    tmc_gate_s gate_q; // Gate control, level status bit unused here
    logic [15:0] cnt_q; // Live count
    logic [7:0] hbuf_q; // High byte buffer for wide access
    logic ovf_q; // Overflow flag, sticky
    logic [1:0] sys_sel_q; // System clock select
    logic idle_on_sleep_q; // Sleep goes to idle when clear
    tmc_pwr_e pwr_q; // Power state
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // Bus decode
    logic [13:0] idx;
    logic word_ok;
    logic setup_rd;
    logic acc_wr;
    assign idx = paddr[15:2];
    assign word_ok = (paddr[1:0] == 2'h0);
    assign setup_rd = psel && !penable && !pwrite;
    assign acc_wr = psel && penable && pwrite && pready_q && word_ok;
    logic wr_ctrl, wr_gate, wr_lo, wr_hi, wr_stat, rd_lo;
    assign wr_ctrl = acc_wr && (idx == IDX_TIMER_CONTROL);
    assign wr_gate = acc_wr && (idx == IDX_GATE_CONTROL);
    assign wr_lo = acc_wr && (idx == IDX_COUNT_LOW);
    assign wr_hi = acc_wr && (idx == IDX_COUNT_HIGH);
    assign wr_stat = acc_wr && (idx == IDX_CLOCK_STATUS);
    assign rd_lo = setup_rd && word_ok && (idx == IDX_COUNT_LOW);
    logic cnt_wr; // Any write touching the count
    assign cnt_wr = wr_lo || (wr_hi && !ctrl_q.wide_access_enable);

    // Two-flop synchronisers for every pin input
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NSYNC-1:0] prev_q;
    assign async_in = {crystal_in_pin, comparator2_out, comparator1_out, gate_pin, crystal_osc_clk, ext_count_input};
    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : g_sync
            // First flop feeds only the second
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                    prev_q[g] <= 1'b0;
                end else begin
                    sync1_q[g] <= async_in[g];
                    sync2_q[g] <= sync1_q[g];
                    prev_q[g] <= sync2_q[g];
                end
            end
        end
    endgenerate

    // Instruction clock phase, one tick in four
    logic [1:0] iph_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iph_q <= 2'h0;
        end else begin
            iph_q <= iph_q + 2'h1;
        end
    end
    logic instr_tick;
    assign instr_tick = (iph_q == INSTR_DIV_LAST);

    // External source: pin, or crystal when oscillator enabled
    logic ext_level, ext_prev, ext_rise;
    assign ext_level = ctrl_q.crystal_osc_enable ? sync2_q[1] : sync2_q[0];
    assign ext_prev = ctrl_q.crystal_osc_enable ? prev_q[1] : prev_q[0];
    assign ext_rise = ext_level && !ext_prev;
    logic ext_mode;
    assign ext_mode = (ctrl_q.clock_source_select == CS_EXTERNAL);

    // Falling edge must be seen before first counted rise
    logic fall_ok_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fall_ok_q <= 1'b0;
        end else if (!ctrl_q.timer_on || cnt_wr) begin
            fall_ok_q <= 1'b0;
        end else if (!ext_level) begin
            fall_ok_q <= 1'b1;
        end
    end

    // Synchronised mode holds an edge until the instruction tick
    logic pend_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 1'b0;
        end else if (ext_rise && fall_ok_q) begin
            pend_q <= 1'b1; // Set wins over consume
        end else if (instr_tick) begin
            pend_q <= 1'b0;
        end
    end

    // Raw clock ticks into the prescaler
    logic src_tick;
    always_comb begin
        case (ctrl_q.clock_source_select)
            CS_SYSTEM: src_tick = 1'b1;
            CS_INSTR: src_tick = instr_tick;
            CS_EXTERNAL: begin
                // Bypass counts the edge at once, else on instruction tick
                if (ctrl_q.ext_sync_bypass) begin
                    src_tick = ext_rise && fall_ok_q;
                end else begin
                    src_tick = pend_q && instr_tick;
                end
            end
            default: src_tick = 1'b0;
        endcase
    end

    // Gate source selection and polarity
    logic gate_raw, gate_act, gate_act_prev_q;
    always_comb begin
        case (gate_q.gate_source_select)
            GS_PIN: gate_raw = sync2_q[2];
            GS_TIMER2: gate_raw = timer2_match_pulse;
            GS_CMP1: gate_raw = sync2_q[3];
            GS_CMP2: gate_raw = sync2_q[4];
            default: gate_raw = 1'b0;
        endcase
    end
    assign gate_act = gate_q.gate_polarity ? gate_raw : !gate_raw;

    // Toggle flip-flop on each rising edge of the active gate
    logic tff_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_act_prev_q <= 1'b0;
            tff_q <= 1'b0;
        end else begin
            gate_act_prev_q <= gate_act;
            if (!gate_q.gate_toggle_mode) begin
                tff_q <= 1'b0;
            end else if (gate_act && !gate_act_prev_q) begin
                tff_q <= !tff_q;
            end
        end
    end
    logic gate_tm, gate_tm_prev_q;
    assign gate_tm = gate_q.gate_toggle_mode ? tff_q : gate_act;

    // Single pulse: open on armed rise, close and disarm on fall
    logic sp_open_q;
    logic sp_rise, sp_fall;
    assign sp_rise = gate_tm && !gate_tm_prev_q;
    assign sp_fall = !gate_tm && gate_tm_prev_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_tm_prev_q <= 1'b0;
            sp_open_q <= 1'b0;
        end else begin
            gate_tm_prev_q <= gate_tm;
            if (!gate_q.gate_single_pulse_mode || sp_fall) begin
                sp_open_q <= 1'b0;
            end else if (gate_q.pulse_arm_done && sp_rise) begin
                sp_open_q <= 1'b1;
            end
        end
    end
    logic gate_final;
    assign gate_final = gate_q.gate_single_pulse_mode ? (sp_open_q && gate_tm) : gate_tm;

    // Count enable; gate enable only matters while on
    logic run;
    assign run = ctrl_q.timer_on && (!gate_q.gate_count_enable || gate_final);

    // Prescaler, ratio 1, 2, 4 or 8
    logic [2:0] psc_q, psc_mask;
    logic inc;
    assign psc_mask = 3'((4'h1 << ctrl_q.prescale_select) - 4'h1);
    assign inc = run && src_tick && ((psc_q & psc_mask) == psc_mask);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psc_q <= 3'h0;
        end else if (wr_lo) begin
            psc_q <= 3'h0;
        end else if (run && src_tick) begin
            psc_q <= psc_q + 3'h1;
        end
    end

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= tmc_ctrl_s'(TIMER_CONTROL_RST);
        end else if (wr_ctrl) begin
            ctrl_q <= tmc_ctrl_s'(pwdata[7:0]);
        end
    end

    // Gate control; arm bit cleared by hardware on the closing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_q <= tmc_gate_s'(GATE_CONTROL_RST);
        end else begin
            if (wr_gate) begin
                gate_q <= tmc_gate_s'(pwdata[7:0]);
                gate_q.gate_level_status <= 1'b0;
                gate_q.pulse_arm_done <= pwdata[3] && pwdata[4];
            end else if (!gate_q.gate_single_pulse_mode) begin
                gate_q.pulse_arm_done <= 1'b0;
            end else if (sp_open_q && sp_fall) begin
                gate_q.pulse_arm_done <= 1'b0;
            end
        end
    end

    // Count and high buffer; a write beats an increment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= COUNT_RST;
            hbuf_q <= 8'h00;
        end else begin
            if (wr_lo) begin
                cnt_q[7:0] <= pwdata[7:0];
                if (ctrl_q.wide_access_enable) begin
                    cnt_q[15:8] <= hbuf_q;
                end
            end else if (wr_hi && !ctrl_q.wide_access_enable) begin
                cnt_q[15:8] <= pwdata[7:0];
            end else if (inc) begin
                cnt_q <= cnt_q + 16'h0001;
            end
            // Otherwise the count holds
            if (wr_hi && ctrl_q.wide_access_enable) begin
                hbuf_q <= pwdata[7:0];
            end else if (rd_lo && ctrl_q.wide_access_enable) begin
                hbuf_q <= cnt_q[15:8];
            end
        end
    end

    // Overflow flag, set wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q <= 1'b0;
        end else if (inc && (cnt_q == 16'hffff) && !cnt_wr) begin
            ovf_q <= 1'b1;
        end else if (wr_stat && pwdata[STAT_OVERFLOW]) begin
            ovf_q <= 1'b0;
        end
    end

    // Clock select and power state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_sel_q <= 2'h0;
            idle_on_sleep_q <= 1'b0;
            pwr_q <= PWR_PRIMARY;
        end else begin
            if (wr_stat) begin
                sys_sel_q <= pwdata[STAT_SYS_SEL_LO +: 2];
                idle_on_sleep_q <= pwdata[STAT_IDLE_ON_SLEEP];
            end
            case (pwr_q)
                PWR_PRIMARY: begin
                    if (wr_stat && pwdata[STAT_SYS_SEL_LO +: 2] == SYS_SEL_CRYSTAL) begin
                        pwr_q <= PWR_SECONDARY_RUN_STATE;
                    end
                end
                PWR_SECONDARY_RUN_STATE: begin
                    if (wr_stat && pwdata[STAT_SYS_SEL_LO +: 2] != SYS_SEL_CRYSTAL) begin
                        pwr_q <= PWR_PRIMARY;
                    end else if (sleep_request && !idle_on_sleep_q) begin
                        pwr_q <= PWR_SECONDARY_IDLE_STATE;
                    end
                end
                PWR_SECONDARY_IDLE_STATE: begin
                    // Wake returns to crystal-clocked run
                    if (wake_request) begin
                        pwr_q <= PWR_SECONDARY_RUN_STATE;
                    end
                end
                default: pwr_q <= PWR_PRIMARY;
            endcase
        end
    end

    // Pin and status outputs, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crystal_pin_oe <= 2'h0;
            crystal_pin_read <= 2'h0;
            crystal_osc_power <= 1'b0;
            secondary_clock_running <= 1'b0;
            power_state <= 3'h1;
        end else begin
            // Direction 1 means input; timer on overrides it
            crystal_pin_oe <= ctrl_q.timer_on ? 2'h0 : ~port_direction;
            crystal_pin_read <= ctrl_q.timer_on ? 2'h0 : {sync2_q[5], sync2_q[0]};
            // Not gated by power state so the crystal keeps running
            crystal_osc_power <= ctrl_q.crystal_osc_enable;
            secondary_clock_running <= (pwr_q != PWR_PRIMARY);
            power_state <= pwr_q;
        end
    end

    // Read mux
    logic [7:0] rd_byte;
    logic rd_hit;
    always_comb begin
        rd_hit = word_ok;
        rd_byte = 8'h00;
        case (idx)
            IDX_TIMER_CONTROL: rd_byte = ctrl_q;
            IDX_GATE_CONTROL: rd_byte = {gate_q[7:3], gate_final, gate_q[1:0]};
            IDX_COUNT_LOW: rd_byte = cnt_q[7:0];
            IDX_COUNT_HIGH: rd_byte = ctrl_q.wide_access_enable ? hbuf_q : cnt_q[15:8];
            IDX_CLOCK_STATUS: rd_byte = {3'h0, idle_on_sleep_q, sys_sel_q, ovf_q, pwr_q != PWR_PRIMARY};
            default: rd_hit = 1'b0;
        endcase
    end

    // APB answer: ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= psel && !penable;
            pslverr_q <= psel && !penable && !rd_hit;
            prdata_q <= (setup_rd && rd_hit) ? {24'h0, rd_byte} : 32'h0;
        end
    end
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_crystal_select;
        wr_stat && pwdata[STAT_SYS_SEL_LO +: 2] == SYS_SEL_CRYSTAL && pwr_q == PWR_PRIMARY;
    endsequence
    sequence s_in_secondary_run_state;
        pwr_q == PWR_SECONDARY_RUN_STATE ##1 secondary_clock_running;
    endsequence

    property p_off_hold;
        !ctrl_q.timer_on && !cnt_wr |=> cnt_q == $past(cnt_q);
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("count moved while off");

    property p_toggle_clear;
        !gate_q.gate_toggle_mode |=> !tff_q;
    endproperty
    a_toggle_clear: assert property (p_toggle_clear) else $error("toggle flop not held clear");

    property p_arm_clear;
        wr_gate && !pwdata[4] |=> !gate_q.pulse_arm_done;
    endproperty
    a_arm_clear: assert property (p_arm_clear) else $error("arm bit survived mode clear");

    property p_overflow;
        inc && cnt_q == 16'hffff && !cnt_wr |=> ovf_q && cnt_q == 16'h0000;
    endproperty
    a_overflow: assert property (p_overflow) else $error("rollover missed overflow");

    property p_low_read_buf;
        rd_lo && ctrl_q.wide_access_enable && !wr_hi |=> hbuf_q == $past(cnt_q[15:8]);
    endproperty
    a_low_read_buf: assert property (p_low_read_buf) else $error("buffer not loaded");

    property p_low_write;
        wr_lo && ctrl_q.wide_access_enable |=> cnt_q == {$past(hbuf_q), $past(pwdata[7:0])};
    endproperty
    a_low_write: assert property (p_low_write) else $error("wide write not atomic");

    property p_pins_input;
        ctrl_q.timer_on |=> crystal_pin_oe == 2'h0 && crystal_pin_read == 2'h0;
    endproperty
    a_pins_input: assert property (p_pins_input) else $error("pins not forced input");

    property p_secondary_run_state;
        s_crystal_select |=> s_in_secondary_run_state;
    endproperty
    a_secondary_run_state: assert property (p_secondary_run_state) else $error("secondary run not entered");

    property p_sec_flag;
        pwr_q == PWR_PRIMARY |=> !secondary_clock_running;
    endproperty
    a_sec_flag: assert property (p_sec_flag) else $error("running flag set on primary");
endmodule

// >>> tb/gated_16bit_timer_counter_tb.sv
// Purpose: Self-checking bench for the gated timer/counter
// Assumes: Zero-wait APB slave, 125 MHz pclk
// Notes: Counting windows are judged with a small tolerance for sync delay
`timescale 1ns/1ns
module gated_16bit_timer_counter_tb;
    import tmc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
    logic sleep_rq = 1'b0, wake_rq = 1'b0, pready, pslverr, se, ext_pin, xtal_clk, xpow, srun;
    logic [15:0] paddr = 16'h0000, cnt;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [3:0] gsrc = 4'h0; // Gate sources: cmp2, cmp1, timer2, pin
    logic [1:0] pdir = 2'h1, oe, pin_rd;
    logic [2:0] pstate;
    logic [13:0] regs [5] = '{IDX_GATE_CONTROL, IDX_TIMER_CONTROL, IDX_COUNT_LOW, IDX_COUNT_HIGH,
        IDX_CLOCK_STATUS};
    logic [7:0] ext_modes [3] = '{8'h85, 8'h81, 8'h89}; // Bypass, synced, crystal
    int err_count = 0, n_tests = 0, cyc = 0;
    // Free-running system clock
    always #4 pclk = ~pclk;
    tmc_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_count_input(ext_pin), .crystal_in_pin(ext_pin), .crystal_osc_clk(xtal_clk),
        .gate_pin(gsrc[0]), .comparator1_out(gsrc[2]), .comparator2_out(gsrc[3]),
        .timer2_match_pulse(gsrc[1]), .port_direction(pdir), .sleep_request(sleep_rq),
        .wake_request(wake_rq), .crystal_pin_oe(oe), .crystal_pin_read(pin_rd), .crystal_osc_power(xpow),
        .secondary_clock_running(srun), .power_state(pstate));
    tmc_ext_pins i_pins (.pclk(pclk), .run(run), .ext_pin(ext_pin), .xtal_clk(xtal_clk));
    task automatic give_verdict();
        $display("checks %0d, errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard, far above the run length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    // One APB transfer; request held until pready is sampled
    task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [13:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rd(input logic [13:0] idx);
        apb(1'b0, idx, 8'h00);
    endtask
    // Range compare; an unknown never passes
    task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        n_tests++;
        if ((got < lo) !== 1'b0 || (got > hi) !== 1'b0) begin
            err_count++;
            $display("unexpected at %0t: got %h, want %h..%h", $time, got, lo, hi);
        end
    endtask
    // Load count, run a window, stop, read count back in 8-bit mode
    task automatic run_cnt(input logic [15:0] st, input logic [7:0] tc, input int n, input logic ext);
        wr(IDX_COUNT_HIGH, st[15:8]);
        wr(IDX_COUNT_LOW, st[7:0]);
        wr(IDX_TIMER_CONTROL, tc);
        run <= ext;
        repeat (n) @(posedge pclk);
        run <= 1'b0;
        repeat (6) @(posedge pclk);
        wr(IDX_TIMER_CONTROL, tc & 8'hfe);
        rd(IDX_COUNT_LOW);
        cnt[7:0] = r[7:0];
        rd(IDX_COUNT_HIGH);
        cnt[15:8] = r[7:0];
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i]) begin
            rd(regs[i]);
            chk(r & 32'hfffffffb, 0, 0);
        end
        chk(32'(oe), 2, 2);
        wr(14'h0001, 8'hff);
        chk({r[30:0], se}, 1, 1);
        for (int p = 0; p < 4; p++) begin
            run_cnt(16'h0, {CS_SYSTEM, p[1:0], 4'h1}, 56, 1'b0);
            chk(32'(cnt), (64 >> p) - 2, (64 >> p) + 1);
        end
        run_cnt(16'h0, {CS_INSTR, 6'h01}, 56, 1'b0);
        chk(32'(cnt), 14, 18);
        for (int k = 0; k < 4; k++) begin
            wr(IDX_GATE_CONTROL, {6'h30, k[1:0]});
            gsrc <= ~(4'h1 << k);
            run_cnt(16'h0, 8'h41, 24, 1'b0);
            chk(32'(cnt), 0, 0);
            gsrc <= 4'h1 << k;
            run_cnt(16'h0, 8'h41, 24, 1'b0);
            chk(32'(cnt), 28, 33);
            rd(IDX_GATE_CONTROL);
            chk(32'(r[2]), 1, 1);
        end
        gsrc <= 4'h0;
        for (int g = 0; g < 2; g++) begin
            wr(IDX_GATE_CONTROL, g ? 8'h40 : 8'h80);
            run_cnt(16'h0, 8'h41, 24, 1'b0);
            chk(32'(cnt), 28, 33);
        end
        wr(IDX_GATE_CONTROL, 8'hd8);
        rd(IDX_GATE_CONTROL);
        chk(32'(r[3]), 1, 1);
        wr(IDX_COUNT_LOW, 8'h00);
        wr(IDX_TIMER_CONTROL, 8'h41);
        repeat (8) @(posedge pclk);
        chk({oe, pin_rd}, 0, 0);
        for (int q = 0; q < 2; q++) begin
            gsrc <= 4'h1;
            repeat (10) @(posedge pclk);
            gsrc <= 4'h0;
            repeat (8) @(posedge pclk);
        end
        wr(IDX_TIMER_CONTROL, 8'h40);
        rd(IDX_GATE_CONTROL);
        chk(32'(r[3]), 0, 0);
        rd(IDX_COUNT_LOW);
        chk(r, 8, 12);
        wr(IDX_GATE_CONTROL, 8'hd8);
        wr(IDX_GATE_CONTROL, 8'hc8);
        rd(IDX_GATE_CONTROL);
        chk(32'(r[3]), 0, 0);
        wr(IDX_GATE_CONTROL, 8'h00);
        wr(IDX_TIMER_CONTROL, 8'h02);
        wr(IDX_COUNT_HIGH, 8'h12);
        wr(IDX_COUNT_LOW, 8'hff);
        wr(IDX_TIMER_CONTROL, 8'h43);
        repeat (6) @(posedge pclk);
        wr(IDX_TIMER_CONTROL, 8'h42);
        rd(IDX_COUNT_HIGH);
        chk(r, 32'h12, 32'h12);
        rd(IDX_COUNT_LOW);
        rd(IDX_COUNT_HIGH);
        chk(r, 32'h13, 32'h13);
        wr(IDX_COUNT_HIGH, 8'h56);
        wr(IDX_TIMER_CONTROL, 8'h00);
        rd(IDX_COUNT_HIGH);
        chk(r, 32'h13, 32'h13);
        foreach (ext_modes[m]) begin
            run_cnt(16'h0, ext_modes[m], 40, 1'b1);
            chk(32'(cnt), 5, 5);
        end
        chk(32'(xpow), 1, 1);
        run_cnt(16'hfff0, 8'h41, 30, 1'b0);
        rd(IDX_CLOCK_STATUS);
        chk(32'(r[1]), 1, 1);
        wr(IDX_CLOCK_STATUS, 8'h04);
        repeat (2) @(posedge pclk);
        chk({srun, pstate}, 32'ha, 32'ha);
        sleep_rq <= 1'b1;
        @(posedge pclk);
        sleep_rq <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({srun, pstate}, 32'hc, 32'hc);
        wake_rq <= 1'b1;
        @(posedge pclk);
        wake_rq <= 1'b0;
        wr(IDX_CLOCK_STATUS, 8'h00);
        repeat (2) @(posedge pclk);
        chk({srun, pstate}, 1, 1);
        give_verdict();
    end
endmodule

// >>> tb/tmc_ext_pins.sv
// Purpose: Far-side model of the count pin and the crystal output
// Assumes: Edges are wanted only while run is high
// Notes: Idles low, so a low level always precedes the first rise
`timescale 1ns/1ns
module tmc_ext_pins (
    input wire logic pclk,
    input wire logic run,
    output logic ext_pin,
    output logic xtal_clk
);
    // Divider for a slow square wave, 4 pclk per half period
    logic [1:0] div_q = 2'h0;
    logic pin_q = 1'b0;
    // Pin stands low outside a burst, never left high
    always @(posedge pclk) begin
        div_q <= run ? div_q + 2'h1 : 2'h0;
        pin_q <= run & ((div_q == 2'h3) ? ~pin_q : pin_q);
    end
    // Crystal output shares the same burst
    assign ext_pin = pin_q;
    assign xtal_clk = pin_q;
endmodule
